// file: rtl/txfr_threshold.sv
/*
 * Transmit FIFO refill threshold logic: decides when a system-bus read is
 * scheduled to refill the transmit FIFO, holds the threshold register and
 * passes fetched words through a two-entry buffer.
 * Assumes all inputs come from logic on sys_clk_i and reset is synchronous.
 */
`timescale 1ns/100ps
// How it works
// - Programmed thresholds bound empty FIFO space before a refill request is scheduled.
// - Empty word count above a threshold schedules a bus refill request.
// - A scheduled request is held back while no transmit descriptor is active.
// - Two low bits of each threshold field are always zero.
// - Reserved bits of the threshold register carry no meaning; they read zero.
// - Soft threshold counts only after four quiet bus clocks.
// - Hard threshold schedules a request at once, whatever the bus does.
module txfr_threshold
(
    // Clock and resets.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic soft_reset_i,
    // Register port.
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // FIFO state and MAC resources.
    input wire logic [txfr_pkg::LEVEL_W-1:0] empty_words_i,
    input wire logic tx_desc_active_i,
    // System bus activity and request handshake.
    input wire logic bus_busy_i,
    output logic bus_req_o,
    input wire logic bus_ack_i,
    // Data from the system bus.
    input wire logic bus_data_valid_i,
    input wire logic [txfr_pkg::DATA_W-1:0] bus_data_i,
    output logic bus_data_ready_o,
    // Data into the transmit FIFO.
    output logic fifo_wr_valid_o,
    output logic [txfr_pkg::DATA_W-1:0] fifo_wr_data_o,
    input wire logic fifo_wr_ready_i
);
    localparam int unsigned LW = txfr_pkg::LEVEL_W;

    logic [LW-1:0] tx_hard_refill_level;
    logic [LW-1:0] tx_soft_refill_level;
    logic [2:0] idle_cnt;
    logic bus_idle;
    logic scheduled;
    logic hard_hit;
    logic soft_hit;
    logic next_scheduled;
    logic flush;

    assign flush = reset_i || soft_reset_i;
    assign bus_idle = (idle_cnt == txfr_pkg::IDLE_CYCLES);
    // A crossing needs strictly more empty words than the level, so an equal count stays quiet.
    assign hard_hit = empty_words_i > tx_hard_refill_level;
    assign soft_hit = bus_idle && (empty_words_i > tx_soft_refill_level);

    // Only chip reset clears the thresholds; soft reset keeps them.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            tx_hard_refill_level <= LW'(txfr_pkg::THRESH_RESET >> txfr_pkg::HARD_LSB);
            tx_soft_refill_level <= LW'(txfr_pkg::THRESH_RESET);
        end
        else if (reg_wr_i && reg_addr_i == txfr_pkg::THRESH_ADDR)
        begin
            // Low bits forced to zero so levels step by four words.
            tx_hard_refill_level <= {reg_wdata_i[txfr_pkg::HARD_MSB:txfr_pkg::HARD_LSB+2],
                2'b00};
            tx_soft_refill_level <= {reg_wdata_i[txfr_pkg::SOFT_MSB:txfr_pkg::SOFT_LSB+2],
                2'b00};
        end
    end

    // Read data stand only in the cycle after the strobe; otherwise the port shows zero.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
        else if (reg_rd_i && reg_addr_i == txfr_pkg::THRESH_ADDR)
        begin
            reg_rdata_o <= 32'h0000_0000;
            reg_rdata_o[txfr_pkg::HARD_MSB:txfr_pkg::HARD_LSB] <= tx_hard_refill_level;
            reg_rdata_o[txfr_pkg::SOFT_MSB:txfr_pkg::SOFT_LSB] <= tx_soft_refill_level;
        end
        else if (reg_rd_i && reg_addr_i == txfr_pkg::STATUS_ADDR)
        begin
            reg_rdata_o <= 32'h0000_0000;
            reg_rdata_o[txfr_pkg::STAT_SCHED] <= scheduled;
            reg_rdata_o[txfr_pkg::STAT_IDLE] <= bus_idle;
            reg_rdata_o[txfr_pkg::STAT_REQ] <= bus_req_o;
        end
        else
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // Counts quiet bus clocks and saturates once the bus is deemed idle.
    always_ff @(posedge sys_clk_i)
    begin
        if (flush || bus_busy_i)
        begin
            idle_cnt <= 3'h0;
        end
        else if (!bus_idle)
        begin
            idle_cnt <= idle_cnt + 3'h1;
        end
    end

    // A new crossing in the acknowledge cycle keeps the request scheduled.
    always_comb
    begin
        next_scheduled = scheduled;
        if (bus_ack_i)
        begin
            next_scheduled = 1'b0;
        end
        if (hard_hit || soft_hit)
        begin
            next_scheduled = 1'b1;
        end
    end

    // Scheduling goes on without a descriptor; only the request to the bus waits for one.
    always_ff @(posedge sys_clk_i)
    begin
        if (flush)
        begin
            scheduled <= 1'b0;
            bus_req_o <= 1'b0;
        end
        else
        begin
            scheduled <= next_scheduled;
            bus_req_o <= next_scheduled && tx_desc_active_i;
        end
    end

    // Soft reset empties the buffer too, so no stale word reaches the FIFO.
    txfr_skid_buf u_buf
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(flush),
        .in_valid_i(bus_data_valid_i),
        .in_data_i(bus_data_i),
        .in_ready_o(bus_data_ready_o),
        .out_valid_o(fifo_wr_valid_o),
        .out_data_o(fifo_wr_data_o),
        .out_ready_i(fifo_wr_ready_i)
    );

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (flush);

    // Four samples with the bus quiet; the idle flag must follow on the next edge.
    sequence quiet_bus_s;
        !bus_busy_i [*4];
    endsequence

    sequence soft_cross_s;
        quiet_bus_s ##1 (empty_words_i > tx_soft_refill_level);
    endsequence

    // A bus grant that meets no fresh crossing must retire the request.
    sequence grant_s;
        bus_req_o && bus_ack_i;
    endsequence

    sequence no_cross_s;
        !hard_hit && !soft_hit;
    endsequence

    // Scheduling, retirement, the descriptor gate and threshold stability.
    req_bound_a: assert property (hard_hit && tx_desc_active_i |=> bus_req_o)
        else $error("hard crossing with active descriptor not raised");
    thresh_keep_a: assert property (!(reg_wr_i && reg_addr_i == txfr_pkg::THRESH_ADDR)
        |=> $stable(tx_hard_refill_level) && $stable(tx_soft_refill_level))
        else $error("threshold changed without a write");
    hard_sched_a: assert property (empty_words_i > tx_hard_refill_level |=> scheduled)
        else $error("hard crossing did not schedule a request");
    ack_clear_a: assert property (grant_s ##0 no_cross_s |=> !scheduled && !bus_req_o)
        else $error("granted request not retired");
    spurious_req_a: assert property (!scheduled ##0 no_cross_s |=> !bus_req_o)
        else $error("request raised without a crossing");
    hold_back_a: assert property (!tx_desc_active_i |=> !bus_req_o)
        else $error("request issued without active descriptor");
    desc_follow_a: assert property (scheduled && tx_desc_active_i && !bus_ack_i
        |=> bus_req_o)
        else $error("scheduled request held back with active descriptor");

    // Register contents as software sees them.
    low_bits_a: assert property (reg_wr_i && reg_addr_i == txfr_pkg::THRESH_ADDR
        |=> tx_hard_refill_level[1:0] == 2'b00 && tx_soft_refill_level[1:0] == 2'b00)
        else $error("threshold low bits not zero");
    rsvd_read_a: assert property (reg_rd_i && reg_addr_i == txfr_pkg::THRESH_ADDR
        |=> reg_rdata_o[31:25] == 7'h00 && reg_rdata_o[15:9] == 7'h00)
        else $error("reserved threshold bits not zero");

    // Bus activity and the two levels.
    soft_idle_a: assert property (soft_cross_s |=> scheduled)
        else $error("soft crossing on idle bus not scheduled");
    idle_reach_a: assert property (quiet_bus_s |=> bus_idle)
        else $error("bus not deemed idle after four quiet clocks");
    busy_reset_a: assert property (bus_busy_i |=> !bus_idle)
        else $error("bus deemed idle right after a transfer");
    soft_busy_a: assert property (!scheduled && $past(bus_busy_i) && !hard_hit
        && !bus_ack_i |=> !scheduled)
        else $error("soft threshold acted on busy bus");
    hard_busy_a: assert property (bus_busy_i && hard_hit && tx_desc_active_i
        |=> scheduled && bus_req_o)
        else $error("hard crossing ignored while bus busy");
    field_map_a: assert property (reg_rd_i && reg_addr_i == txfr_pkg::THRESH_ADDR
        |=> reg_rdata_o[24:16] == $past(tx_hard_refill_level)
        && reg_rdata_o[8:0] == $past(tx_soft_refill_level))
        else $error("threshold fields read back at wrong place");
endmodule

// file: include/txfr_pkg.sv
/*
 * Constants for the transmit FIFO refill threshold block: the register map,
 * field positions, reset values and the bus idle count.
 * Assumes a 32-bit register port and a 9-bit empty-word count from the FIFO.
 */
package txfr_pkg;
    localparam int unsigned LEVEL_W = 9;
    localparam int unsigned DATA_W = 32;
    localparam logic [31:0] THRESH_ADDR = 32'h8001_00d4;
    localparam logic [31:0] STATUS_ADDR = 32'h8001_01f0;
    localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
    localparam int unsigned HARD_LSB = 16;
    localparam int unsigned HARD_MSB = 24;
    localparam int unsigned SOFT_LSB = 0;
    localparam int unsigned SOFT_MSB = 8;
    localparam int unsigned STAT_SCHED = 0;
    localparam int unsigned STAT_IDLE = 1;
    localparam int unsigned STAT_REQ = 2;
    localparam logic [2:0] IDLE_CYCLES = 3'h4;
endpackage

// file: rtl/txfr_skid_buf.sv
/*
 * Two-entry buffer in the transmit data path, from the system bus to the FIFO.
 * Assumes reset is synchronous and that the sink may stall at any time.
 */
`timescale 1ns/100ps
module txfr_skid_buf
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Filling side.
    input wire logic in_valid_i,
    input wire logic [txfr_pkg::DATA_W-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side.
    output logic out_valid_o,
    output logic [txfr_pkg::DATA_W-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic skid_valid;
    logic [txfr_pkg::DATA_W-1:0] skid_data;

    // The second entry catches a word taken while the output stalls.
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            out_valid_o <= 1'b0;
            skid_valid <= 1'b0;
            in_ready_o <= 1'b1;
        end
        else if (!out_valid_o || out_ready_i)
        begin
            if (skid_valid)
            begin
                out_valid_o <= 1'b1;
                skid_valid <= 1'b0;
                in_ready_o <= 1'b1;
            end
            else
            begin
                out_valid_o <= in_valid_i && in_ready_o;
            end
        end
        else if (in_valid_i && in_ready_o)
        begin
            skid_valid <= 1'b1;
            in_ready_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!out_valid_o || out_ready_i)
        begin
            out_data_o <= skid_valid ? skid_data : in_data_i;
        end
        if (out_valid_o && !out_ready_i && in_valid_i && in_ready_o)
        begin
            skid_data <= in_data_i;
        end
    end
endmodule

// file: bench/txfr_bus_model.sv
/* Behavioural system bus: acks a refill request and returns two words.
   Assumes the bench drives hold_busy_i to mimic other bus traffic. */
`timescale 1ns/100ps
module txfr_bus_model
#(
    parameter logic [31:0] FIRST_WORD = 32'h0000_1000
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Request and bus activity.
    input wire logic bus_req_i,
    input wire logic hold_busy_i,
    output logic bus_ack_o,
    output logic bus_busy_o,
    // Fetched words.
    output logic data_valid_o,
    output logic [31:0] data_o,
    input wire logic data_ready_i
);
    logic [1:0] left;
    logic [31:0] word;
    // Owed beats keep the bus busy; an idle data bus shows the inverse word.
    assign bus_busy_o = hold_busy_i | (left != 2'h0);
    assign data_valid_o = left != 2'h0;
    assign data_o = data_valid_o ? word : ~word;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            bus_ack_o <= 1'h0;
            left <= 2'h0;
            word <= FIRST_WORD;
        end
        else
        begin
            bus_ack_o <= bus_req_i & ~bus_ack_o & (left == 2'h0);
            if (bus_ack_o)
                left <= 2'h2;
            else if (data_valid_o & data_ready_i)
            begin
                left <= left - 2'h1;
                word <= word + 32'h1;
            end
        end
    end
endmodule

// file: bench/txfr_threshold_bench.sv
/* Self-checking bench for the refill threshold block.
   Assumes the bus model in txfr_bus_model.sv on the far side. */
`timescale 1ns/100ps
module txfr_threshold_bench;
    logic clk = 1'h0, rst = 1'h1, srst = 1'h0, wr = 1'h0, rd = 1'h0;
    logic desc = 1'h1, hold = 1'h1, fr = 1'h1, req, ack, busy, dv, dr, fv;
    logic [31:0] ra = 32'h0, wd = 32'h0, rdata, dd, fd, seen;
    logic [31:0] exp_word = 32'h0000_1000;
    logic [8:0] empty = 9'h0;
    int fails = 0, samples_checked = 0, t;
    localparam logic [31:0] TA = txfr_pkg::THRESH_ADDR;
    localparam logic [31:0] SA = txfr_pkg::STATUS_ADDR;
    initial
    begin
        forever #5 clk = ~clk;
    end
    txfr_threshold dut (.sys_clk_i(clk), .reset_i(rst), .soft_reset_i(srst),
        .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .empty_words_i(empty), .tx_desc_active_i(desc), .bus_busy_i(busy), .bus_req_o(req),
        .bus_ack_i(ack), .bus_data_valid_i(dv), .bus_data_i(dd), .bus_data_ready_o(dr),
        .fifo_wr_valid_o(fv), .fifo_wr_data_o(fd), .fifo_wr_ready_i(fr));
    txfr_bus_model far (.sys_clk_i(clk), .reset_i(rst), .bus_req_i(req), .hold_busy_i(hold),
        .bus_ack_o(ack), .bus_busy_o(busy), .data_valid_o(dv), .data_o(dd), .data_ready_i(dr));
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        ra <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [31:0] a);
        ra <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 seen = rdata;
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Any request seen during the span is a mismatch.
    task automatic quiet(input int n);
        logic any;
        any = 1'h0;
        repeat (n)
        begin
            cyc(1);
            any = any | req;
        end
        check("no request", {31'h0, any}, 32'h0);
    endtask
    task automatic wait_req(input int lim);
        t = 0;
        while (req !== 1'h1)
        begin
            cyc(1);
            t++;
            if (t > lim)
            begin
                check("request wait", 32'h0, 32'h1);
                final_report();
            end
        end
    endtask
    always @(posedge clk)
        if (!rst && fv === 1'h1 && fr === 1'h1)
        begin
            check("fifo word", fd, exp_word);
            exp_word <= exp_word + 32'h1;
        end
    // Register port: reset value, field map, reserved bits, unmapped address, soft reset.
    task automatic reg_scenario();
        reg_rd(TA);
        check("thresh reset", seen, 32'h0);
        reg_wr(TA, 32'hfffc_fffc);
        reg_rd(TA);
        check("thresh fields", seen, 32'h01fc_01fc);
        reg_rd(TA + 32'h4);
        check("unmapped", seen, 32'h0);
        reg_wr(TA, 32'h0020_0010);
        srst <= 1'h1;
        @(posedge clk);
        srst <= 1'h0;
        reg_rd(TA);
        check("soft reset keeps", seen, 32'h0020_0010);
    endtask
    // Hard level: an equal count stays quiet, one step above raises the request at once.
    task automatic hard_scenario();
        empty <= 9'h020;
        quiet(8);
        empty <= 9'h024;
        wait_req(2);
        empty <= 9'h000;
        cyc(8);
    endtask
    // Soft level: ignored while the bus is busy, acted on after four quiet clocks.
    task automatic soft_scenario();
        empty <= 9'h014;
        quiet(8);
        hold <= 1'h0;
        wait_req(8);
        check("soft delay", t, 32'h5);
        empty <= 9'h000;
        hold <= 1'h1;
        cyc(8);
    endtask
    // No descriptor: scheduled but held back; a stalled FIFO then fills the buffer.
    task automatic desc_scenario();
        desc <= 1'h0;
        fr <= 1'h0;
        empty <= 9'h030;
        quiet(6);
        reg_rd(SA);
        check("status held", seen, 32'h1);
        desc <= 1'h1;
        wait_req(3);
        empty <= 9'h000;
        cyc(8);
        check("buffer full", {30'h0, dr, fv}, 32'h1);
        fr <= 1'h1;
        cyc(6);
        check("word count", exp_word, 32'h0000_1006);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        reg_scenario();
        hard_scenario();
        soft_scenario();
        desc_scenario();
        final_report();
    end
endmodule
